/* hdl/itwl_pkg.sv */
// package: constants, types and parity helper for the inter-die link bridge
// Operation
// (RULE1) link is data, serial clock at core clock over eight, and interrupt
// (RULE2) host access to either converter setup register starts a link transfer
// (RULE3) far end raises interrupt to ask for a status read
// (RULE4) each link write is read back and compared; on after reset; calibration writes (JOB_CAL) are not read back here
// (RULE5) transfer lasts about 300 us with read-back, 30 us without
// (RULE6) busy flag reads set for the whole link transaction
// (RULE7) writing a new output range refreshes calibration over the link, busy set
// (RULE8) host must not start a converter setup write while busy
// (RULE9) a write arriving during a transfer is held until it completes
// (RULE10) far-end fault interrupt makes the master read far-end status
// (RULE11) three copied fault bits shown in analog results and status OR
// (RULE12) any copied fault bit drives the fault pin
// (RULE13) each new interrupt rise starts another status read
// (RULE14) after six detections, detection stops until a link write completes
// (RULE15) saturation flag set by that limit, cleared by setup register write
// (RULE16) parity over address and data; mismatch sets link parity error
// (RULE17) with read-back on, parity error also sets integrity error
// (RULE18) setup bits inject faults into the link parity
// (RULE19) overvoltage bit set when output leaves the supply window
// (RULE20) frames MSB first, even parity each for address and data, rising edge
// (RULE21) read-back mismatch sets the integrity error bit
package itwl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_DIV = 8;
    localparam logic [2:0] DIV_LAST = 3'(SCLK_DIV - 1);
    localparam logic [2:0] DIV_RISE = 3'(SCLK_DIV / 2 - 1);
    // register byte addresses
    localparam logic [7:0] RA_SETUP_ONE = 8'h00;
    localparam logic [7:0] RA_SETUP_TWO = 8'h04;
    localparam logic [7:0] RA_GEN_TWO = 8'h08;
    localparam logic [7:0] RA_RANGE = 8'h0C;
    localparam logic [7:0] RA_ANALOG = 8'h10;
    localparam logic [7:0] RA_DIGITAL = 8'h14;
    localparam logic [7:0] RA_STATUS = 8'h18;
    // field positions and reset values
    localparam int SETUP2_SAT_BIT = 14;
    localparam int SETUP2_BUSY_BIT = 15;
    localparam int GEN2_RB_EN_BIT = 0;
    localparam int GEN2_INJ_AP_BIT = 1;
    localparam int GEN2_INJ_DP_BIT = 2;
    localparam logic [2:0] GEN2_RST = 3'h1;
    localparam int DIG_PAR_BIT = 0;
    localparam int DIG_BKG_BIT = 1;
    localparam int STAT_FAULT_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    // far-end register addresses
    localparam logic [2:0] RM_SETUP_ONE = 3'h1;
    localparam logic [2:0] RM_SETUP_TWO = 3'h2;
    localparam logic [2:0] RM_STATUS = 3'h3;
    localparam logic [2:0] RM_CAL = 3'h4;
    // frame lengths in bits and interrupt saturation limit
    localparam logic [4:0] TX_RD_BITS = 5'h05;
    localparam logic [4:0] TX_WR_BITS = 5'h16;
    localparam logic [4:0] RX_BITS = 5'h11;
    localparam logic [2:0] IRQ_SAT_LIMIT = 3'h6;
    // transfer timing
    localparam int LINK_GAP_NS = 30000;
    localparam logic [15:0] LINK_GAP_CYC = 16'(LINK_GAP_NS / CLK_PERIOD_NS);
    localparam int RB_TIME_NS = 270000;
    localparam int RB_WAIT_DEF = RB_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LAUNCH, ST_TX, ST_RX, ST_GAP, ST_RBWAIT
    } itwl_state_t;
    typedef enum logic [2:0] {
        JOB_WR, JOB_RD, JOB_STAT, JOB_RB, JOB_CAL
    } itwl_job_t;

    // even parity bit of a word
    function automatic logic itwl_par(input logic [15:0] v);
        return ^v;
    endfunction
endpackage

/* hdl/itwl_link_top.sv */
// module: main-die master of the inter-die three-wire link with its registers
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
module itwl_link_top import itwl_pkg::*; #(
    parameter int unsigned RB_WAIT_CYC = RB_WAIT_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic link_serial_clock,
    output logic link_data_o,
    output logic link_data_oe,
    input wire logic link_data_i,
    input wire logic link_irq,
    output logic fault_n
);
    logic rst_meta_reg, rst_sync_n_reg;
    logic [2:0] div_reg;
    itwl_state_t st_reg;
    itwl_job_t job_reg;
    logic [2:0] cur_addr_reg;
    logic [21:0] sh_reg;
    logic [16:0] rx_sh_reg;
    logic [4:0] bits_left_reg;
    logic [15:0] cnt_reg;
    logic sclk_reg, data_o_reg, oe_reg, rx_done_reg, wr_done_reg;
    logic [15:0] setup_one_reg;
    logic [13:0] setup_two_reg;
    logic [2:0] gen_two_reg;
    logic [4:0] range_reg;
    logic [2:0] fault_copy_reg;
    logic par_err_reg, bkg_err_reg, irq_sat_reg, irq_off_reg;
    logic [2:0] irq_cnt_reg;
    logic irq_prev_reg, irq_pend_reg;
    logic pend_v_reg, pend_rw_reg, cal_pend_reg;
    logic [2:0] pend_addr_reg;
    logic [15:0] rdata_reg;
    logic fault_n_reg;

    logic fall_tick, rise_tick, in_frame, cur_wr, rb_en, busy;
    logic host_setup, host_rem_wr, host_rem_req, host_keep;
    logic take_pend, take_cal, take_irq, irq_det;
    logic [15:0] cur_copy, frame_data, rx_data;
    logic [21:0] frame;
    logic rx_par_bad;

    assign reg_rdata = rdata_reg;
    assign link_serial_clock = sclk_reg;
    assign link_data_o = data_o_reg;
    assign link_data_oe = oe_reg;
    assign fault_n = fault_n_reg;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // decode and shared terms
    assign fall_tick = (div_reg == DIV_LAST);
    assign rise_tick = (div_reg == DIV_RISE);
    assign in_frame = (st_reg == ST_TX) || (st_reg == ST_RX);
    assign cur_wr = (job_reg == JOB_WR) || (job_reg == JOB_CAL);
    assign rb_en = gen_two_reg[GEN2_RB_EN_BIT];
    assign busy = (st_reg != ST_IDLE) || pend_v_reg || cal_pend_reg; // RULE6
    assign host_setup = (reg_addr == RA_SETUP_ONE)
        || (reg_addr == RA_SETUP_TWO);
    assign host_rem_wr = reg_wr && host_setup;
    assign host_rem_req = (reg_wr || reg_rd) && host_setup; // RULE2
    // a read never displaces a held write; reads return the local copy
    assign host_keep = pend_v_reg && pend_rw_reg && reg_rd && !take_pend;
    assign take_pend = (st_reg == ST_IDLE) && pend_v_reg;
    assign take_cal = (st_reg == ST_IDLE) && !pend_v_reg && cal_pend_reg;
    assign take_irq = (st_reg == ST_IDLE) && !pend_v_reg && !cal_pend_reg
        && irq_pend_reg;
    assign irq_det = link_irq && !irq_prev_reg && !irq_off_reg; // RULE13
    assign cur_copy = (cur_addr_reg == RM_SETUP_ONE) ? setup_one_reg
        : {2'h0, setup_two_reg};
    assign frame_data = (job_reg == JOB_CAL) ? {11'h000, range_reg}
        : cur_copy;
    // rw, address, address parity, data, data parity, MSB first
    assign frame = {cur_wr, cur_addr_reg,
        itwl_par({12'h000, cur_wr, cur_addr_reg})
            ^ gen_two_reg[GEN2_INJ_AP_BIT], // RULE18
        frame_data, itwl_par(frame_data)}; // RULE20
    assign rx_data = rx_sh_reg[16:1];
    assign rx_par_bad = rx_sh_reg[0]
        != (itwl_par(rx_data) ^ gen_two_reg[GEN2_INJ_DP_BIT]); // RULE16

    // serial clock divider, free running; pin only toggles inside frames
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            div_reg <= 3'h0;
            sclk_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            sclk_reg <= in_frame && (div_reg >= DIV_RISE)
                && (div_reg < DIV_LAST); // RULE1
        end
    end

    // transfer sequencer: pick a job, shift it out, wait, read back
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            st_reg <= ST_IDLE;
            job_reg <= JOB_RD;
            cur_addr_reg <= 3'h0;
            sh_reg <= 22'h000000;
            rx_sh_reg <= 17'h00000;
            bits_left_reg <= 5'h00;
            cnt_reg <= 16'h0000;
            data_o_reg <= 1'b0;
            oe_reg <= 1'b0;
            rx_done_reg <= 1'b0;
            wr_done_reg <= 1'b0;
        end else begin
            rx_done_reg <= 1'b0;
            wr_done_reg <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (take_pend) begin // RULE9
                        job_reg <= pend_rw_reg ? JOB_WR : JOB_RD;
                        cur_addr_reg <= pend_addr_reg;
                        st_reg <= ST_LAUNCH;
                    end else if (take_cal) begin // RULE7
                        job_reg <= JOB_CAL;
                        cur_addr_reg <= RM_CAL;
                        st_reg <= ST_LAUNCH;
                    end else if (take_irq) begin // RULE10
                        job_reg <= JOB_STAT;
                        cur_addr_reg <= RM_STATUS;
                        st_reg <= ST_LAUNCH;
                    end
                end
                ST_LAUNCH: begin
                    // frames start on a falling serial clock edge
                    if (fall_tick) begin
                        data_o_reg <= frame[21];
                        sh_reg <= {frame[20:0], 1'b0};
                        oe_reg <= 1'b1;
                        bits_left_reg <= cur_wr ? TX_WR_BITS : TX_RD_BITS;
                        st_reg <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (fall_tick) begin
                        if (bits_left_reg == 5'h01) begin
                            oe_reg <= 1'b0;
                            data_o_reg <= 1'b0;
                            if (!cur_wr) begin
                                bits_left_reg <= RX_BITS;
                                st_reg <= ST_RX;
                            end else if (job_reg == JOB_WR && rb_en) begin
                                cnt_reg <= 16'(RB_WAIT_CYC); // RULE5
                                st_reg <= ST_RBWAIT; // RULE4
                            end else begin
                                cnt_reg <= LINK_GAP_CYC; // RULE5
                                st_reg <= ST_GAP;
                            end
                        end else begin
                            data_o_reg <= sh_reg[21];
                            sh_reg <= {sh_reg[20:0], 1'b0};
                            bits_left_reg <= bits_left_reg - 5'h01;
                        end
                    end
                end
                ST_RX: begin
                    // sample where the serial clock rises
                    if (rise_tick) begin
                        rx_sh_reg <= {rx_sh_reg[15:0], link_data_i};
                        if (bits_left_reg == 5'h01) begin
                            rx_done_reg <= 1'b1;
                            cnt_reg <= LINK_GAP_CYC;
                            st_reg <= ST_GAP;
                        end else begin
                            bits_left_reg <= bits_left_reg - 5'h01;
                        end
                    end
                end
                ST_RBWAIT: begin
                    if (cnt_reg == 16'h0000) begin
                        job_reg <= JOB_RB; // RULE4
                        st_reg <= ST_LAUNCH;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                ST_GAP: begin
                    if (cnt_reg == 16'h0000) begin
                        wr_done_reg <= cur_wr || (job_reg == JOB_RB);
                        st_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // host-written registers and held requests; sets win over takes
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            setup_one_reg <= 16'h0000;
            setup_two_reg <= 14'h0000;
            gen_two_reg <= GEN2_RST; // RULE4
            range_reg <= 5'h00;
            pend_v_reg <= 1'b0;
            pend_rw_reg <= 1'b0;
            pend_addr_reg <= 3'h0;
            cal_pend_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == RA_SETUP_ONE)
                setup_one_reg <= reg_wdata;
            if (reg_wr && reg_addr == RA_SETUP_TWO)
                setup_two_reg <= reg_wdata[13:0];
            if (reg_wr && reg_addr == RA_GEN_TWO)
                gen_two_reg <= reg_wdata[2:0]; // RULE18
            if (reg_wr && reg_addr == RA_RANGE)
                range_reg <= reg_wdata[4:0];
            if (reg_wr && reg_addr == RA_RANGE
                && reg_wdata[4:0] != range_reg)
                cal_pend_reg <= 1'b1; // RULE7
            else if (take_cal)
                cal_pend_reg <= 1'b0;
            // a write during a transfer waits here, newest one kept
            if (host_rem_req && !host_keep) begin // RULE9
                pend_v_reg <= 1'b1;
                pend_rw_reg <= reg_wr;
                pend_addr_reg <= (reg_addr == RA_SETUP_ONE) ? RM_SETUP_ONE
                    : RM_SETUP_TWO;
            end else if (take_pend) begin
                pend_v_reg <= 1'b0;
            end
        end
    end

    // interrupt detection with saturation limit
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            irq_prev_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
            irq_cnt_reg <= 3'h0;
            irq_off_reg <= 1'b0;
            irq_sat_reg <= 1'b0;
        end else begin
            irq_prev_reg <= link_irq;
            if (irq_det)
                irq_pend_reg <= 1'b1; // RULE3
            else if (take_irq)
                irq_pend_reg <= 1'b0;
            // a finished write re-arms detection; count is per write
            if (wr_done_reg) begin
                irq_cnt_reg <= 3'h0;
                irq_off_reg <= 1'b0; // RULE14
            end else if (irq_det) begin
                irq_cnt_reg <= irq_cnt_reg + 3'h1;
                if (irq_cnt_reg == IRQ_SAT_LIMIT - 3'h1)
                    irq_off_reg <= 1'b1; // RULE14
            end
            if (irq_det && irq_cnt_reg == IRQ_SAT_LIMIT - 3'h1)
                irq_sat_reg <= 1'b1; // RULE15
            else if (host_rem_wr)
                irq_sat_reg <= 1'b0; // RULE15
        end
    end

    // results of received frames: fault copies, parity, compare
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            fault_copy_reg <= 3'h0;
            par_err_reg <= 1'b0;
            bkg_err_reg <= 1'b0;
            fault_n_reg <= 1'b1;
        end else begin
            // a corrupted status word is not trusted
            if (rx_done_reg && job_reg == JOB_STAT && !rx_par_bad)
                fault_copy_reg <= rx_data[2:0]; // RULE11 RULE19
            if (rx_done_reg && rx_par_bad)
                par_err_reg <= 1'b1; // RULE16
            else if (reg_wr && reg_addr == RA_DIGITAL
                && reg_wdata[DIG_PAR_BIT])
                par_err_reg <= 1'b0;
            if (rx_done_reg && ((rx_par_bad && rb_en) // RULE17
                || ((job_reg == JOB_RB || job_reg == JOB_RD)
                && rx_data != cur_copy))) // RULE21
                bkg_err_reg <= 1'b1;
            else if (reg_wr && reg_addr == RA_DIGITAL
                && reg_wdata[DIG_BKG_BIT])
                bkg_err_reg <= 1'b0;
            fault_n_reg <= ~|fault_copy_reg; // RULE12
        end
    end

    // register read data, valid the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    RA_SETUP_ONE: rdata_reg <= setup_one_reg;
                    RA_SETUP_TWO: rdata_reg <= {busy, irq_sat_reg,
                        setup_two_reg}; // RULE6
                    RA_GEN_TWO: rdata_reg <= {13'h0000, gen_two_reg};
                    RA_RANGE: rdata_reg <= {11'h000, range_reg};
                    RA_ANALOG: rdata_reg <= {13'h0000, fault_copy_reg};
                    RA_DIGITAL: rdata_reg <= {14'h0000, bkg_err_reg,
                        par_err_reg};
                    RA_STATUS: rdata_reg <= {14'h0000, busy,
                        |fault_copy_reg}; // RULE11
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n_reg);

    sequence s_low_half;
        !link_serial_clock [*4];
    endsequence
    property p_sclk_div;
        $fell(link_serial_clock) && in_frame |-> s_low_half
            ##1 link_serial_clock;
    endproperty
    a_sclk_div: assert property (p_sclk_div) // RULE1
        else $error("serial clock low phase not four cycles");

    sequence s_idle_free;
        st_reg == ST_IDLE && !pend_v_reg && !cal_pend_reg
            && !irq_pend_reg;
    endsequence
    property p_launch;
        s_idle_free and host_rem_wr |-> ##[3:12] st_reg == ST_TX;
    endproperty
    a_launch: assert property (p_launch) // RULE2
        else $error("setup write did not start a link frame");

    property p_hold;
        reg_wr && host_setup && st_reg != ST_IDLE |=> pend_v_reg
            && pend_rw_reg;
    endproperty
    a_hold: assert property (p_hold) // RULE9
        else $error("write during transfer not held");

    property p_busy;
        reg_rd && reg_addr == RA_SETUP_TWO && st_reg != ST_IDLE
            |=> reg_rdata[SETUP2_BUSY_BIT];
    endproperty
    a_busy: assert property (p_busy) // RULE6
        else $error("busy flag clear during transfer");

    property p_readback;
        st_reg == ST_TX && fall_tick && bits_left_reg == 5'h01
            && job_reg == JOB_WR && rb_en |=> st_reg == ST_RBWAIT;
    endproperty
    a_readback: assert property (p_readback) // RULE4
        else $error("write not followed by read-back wait");

    property p_irq_sat;
        irq_det && irq_cnt_reg == 3'h5 && !wr_done_reg
            |=> irq_off_reg && irq_sat_reg;
    endproperty
    a_irq_sat: assert property (p_irq_sat) // RULE15
        else $error("sixth interrupt did not saturate");

    property p_irq_off;
        irq_off_reg && !wr_done_reg |=> $stable(irq_cnt_reg);
    endproperty
    a_irq_off: assert property (p_irq_off) // RULE14
        else $error("interrupt counted while detection off");

    property p_fault_pin;
        (|fault_copy_reg) |=> !fault_n;
    endproperty
    a_fault_pin: assert property (p_fault_pin) // RULE12
        else $error("fault pin not driven by fault copy");

    property p_parity;
        rx_done_reg && rx_par_bad && rb_en |=> par_err_reg && bkg_err_reg;
    endproperty
    a_parity: assert property (p_parity) // RULE17
        else $error("parity error not recorded");
endmodule

/* verification/itwl_far_model.sv */
// far-end converter-die slave model for the inter-die link
`timescale 1ns/10ps
module itwl_far_model (
    input wire logic link_serial_clock,
    input wire logic link_data_o,
    input wire logic link_data_oe,
    output logic link_data_i,
    output logic link_irq,
    input wire logic irq_cmd,
    input wire logic [2:0] stat_bits,
    input wire logic flip_data
);
    logic [15:0] mem [0:7] = '{default: 16'h0000};
    logic [21:0] sh = 22'h000000;
    logic [16:0] out = 17'h00000;
    int n = 0;
    int cnt = 0;
    int n_rd = 0;
    int n_perr = 0;
    bit rd = 0;
    // interrupt raised only when the bench raises irq_cmd, fault or not
    assign link_irq = irq_cmd;
    // frames arrive msb first, sampled on the rising link clock
    always @(posedge link_serial_clock) begin
        if (rd) begin
            cnt++;
            if (cnt == 17)
                rd = 0;
        end else if (link_data_oe) begin
            sh = {sh[20:0], link_data_o};
            n++;
            if (n == 5 && !sh[4]) begin
                if (^sh[4:0])
                    n_perr++;
                out[16:1] = sh[3:1] == 3'h3 ? {13'h0000, stat_bits}
                    : mem[sh[3:1]];
                // a flipped bit keeps good parity: only compare can see it
                out[16:1] = out[16:1] ^ {15'h0000, flip_data};
                out[0] = ^out[16:1];
                rd = 1;
                cnt = 0;
                n = 0;
                n_rd++;
            end else if (n == 22) begin
                // a frame with bad parity is dropped, not stored
                if (^sh[21:17] || ^sh[16:0])
                    n_perr++;
                else
                    mem[sh[20:18]] = sh[16:1];
                n = 0;
            end
        end
    end
    // reply bits change on the falling clock; released line shows inverse
    initial link_data_i = 1'b0;
    always @(negedge link_serial_clock)
        link_data_i <= rd ? out[16 - cnt] : ~link_data_i;
endmodule

/* verification/tb.sv */
// self-checking bench for the inter-die link master
`timescale 1ns/10ps
module tb;
    import itwl_pkg::*;
    logic ref_clk = 0;
    logic rst_n = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [15:0] reg_rdata;
    logic sclk;
    logic d_o;
    logic d_oe;
    logic d_i;
    logic irq;
    logic fault_n;
    logic irq_cmd = 0;
    logic [2:0] stat_bits = 3'h0;
    logic flip_data = 0;
    logic [31:0] seed = 32'h7BFFB734;
    logic [15:0] v;
    logic [15:0] a;
    logic [15:0] b;
    int n_fail = 0;
    int check_count = 0;
    int t0;
    int cyc = 0;
    // short read-back wait keeps the run brief
    itwl_link_top #(.RB_WAIT_CYC(50)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_serial_clock(sclk),
        .link_data_o(d_o), .link_data_oe(d_oe), .link_data_i(d_i),
        .link_irq(irq), .fault_n(fault_n));
    itwl_far_model p (.link_serial_clock(sclk), .link_data_o(d_o),
        .link_data_oe(d_oe), .link_data_i(d_i), .link_irq(irq),
        .irq_cmd(irq_cmd), .stat_bits(stat_bits), .flip_data(flip_data));
    // clock and cycle count
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [15:0] g,
                       input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bus cycles: one-cycle strobes, read data in the next cycle only
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= ad;
        reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic rc(input string nm, input logic [7:0] ad,
                      input logic [15:0] e);
        rd(ad, v);
        chk(nm, v, e);
    endtask
    // poll busy in status: reading a setup register would queue a link read
    task automatic idle();
        for (int i = 0; i < 5000; i++) begin
            rd(RA_STATUS, v);
            if (v[STAT_BUSY_BIT] === 1'b0)
                return;
        end
        n_fail++;
        report_and_stop();
    endtask
    task automatic pulse(input logic [2:0] s);
        @(posedge ref_clk);
        stat_bits <= s;
        irq_cmd <= 1;
        repeat (4) @(posedge ref_clk);
        irq_cmd <= 0;
        repeat (4) @(posedge ref_clk);
        idle();
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        repeat (3) @(posedge ref_clk);
        rc("gen2", RA_GEN_TWO, 16'h0001);
        rc("dig", RA_DIGITAL, 16'h0000);
        rc("stat", RA_STATUS, 16'h0000);
        rc("unmapped", 8'h1C, 16'h0000);
        chk("fault_n", {15'h0000, fault_n}, 16'h0001);
        // this read also runs a link read; let it finish before timing
        rc("setup2", RA_SETUP_TWO, 16'h0000);
        idle();
        wr(RA_GEN_TWO, 16'h0000);
        seed = lfsr(seed);
        a = seed[15:0];
        t0 = cyc;
        wr(RA_SETUP_ONE, a);
        rc("busy", RA_STATUS, 16'h0002);
        idle();
        chk("t_off", 16'(cyc - t0 > 3100 && cyc - t0 < 3300), 16'h0001);
        chk("far1", p.mem[1], a);
        // second write lands while busy and must be held
        wr(RA_GEN_TWO, 16'h0001);
        b = seed[31:16];
        wr(RA_SETUP_ONE, ~a);
        wr(RA_SETUP_TWO, b);
        idle();
        chk("far1b", p.mem[1], ~a);
        chk("far2", p.mem[2], {2'b00, b[13:0]});
        rc("dig_ok", RA_DIGITAL, 16'h0000);
        flip_data <= 1;
        rd(RA_SETUP_ONE, v);
        idle();
        flip_data <= 0;
        rc("mism", RA_DIGITAL, 16'h0002);
        wr(RA_DIGITAL, 16'h0003);
        // injected data parity, read-back off then on
        for (int k = 0; k < 2; k++) begin
            wr(RA_GEN_TWO, 16'h0004 + 16'(k));
            rd(RA_SETUP_ONE, v);
            idle();
            rc("par", RA_DIGITAL, 16'h0001 + 16'(2 * k));
            wr(RA_DIGITAL, 16'h0003);
        end
        rc("w1c", RA_DIGITAL, 16'h0000);
        wr(RA_GEN_TWO, 16'h0002);
        t0 = p.n_perr;
        wr(RA_SETUP_ONE, a);
        idle();
        chk("inject", 16'(p.n_perr - t0), 16'h0001);
        wr(RA_GEN_TWO, 16'h0001);
        wr(RA_RANGE, {11'h000, seed[4:0] | 5'h01});
        rc("busy_r", RA_SETUP_TWO, {2'b10, b[13:0]});
        idle();
        chk("cal", p.mem[4], {11'h000, seed[4:0] | 5'h01});
        for (int k = 1; k <= 6; k++) begin
            seed = lfsr(seed);
            pulse(k == 6 ? 3'h0 : seed[2:0] | 3'h1);
            rc("analog", RA_ANALOG, {13'h0000, stat_bits});
            rc("st", RA_STATUS, {15'h0000, |stat_bits});
            chk("flt", {15'h0000, fault_n}, {15'h0000, ~|stat_bits});
        end
        rc("sat", RA_SETUP_TWO, {2'b01, b[13:0]});
        idle();
        t0 = p.n_rd;
        pulse(3'h7);
        chk("no_rd", 16'(p.n_rd - t0), 16'h0000);
        wr(RA_SETUP_ONE, a);
        rc("sat_clr", RA_SETUP_TWO, {2'b10, b[13:0]});
        idle();
        report_and_stop();
    end
endmodule
